// ==== design/spqv_port_ctrl.sv ====
/*
 * Per-port control bank of a three-port switch: two byte registers per port
 * steering storm protection, classification, tagging, mirroring and VLAN
 * membership. Assumes strap inputs stable around reset release, and datapath
 * query inputs synchronous to clk_i.
 */
module spqv_port_ctrl
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Straps, one bit per port (two per port for member_strap_i), index 0 is port 1
  input wire logic [2:0] dot1p_strap_i,
  input wire logic [2:0] port_prio_strap_i,
  input wire logic [2:0] tag_add_strap_i,
  input wire logic [2:0] tag_strip_strap_i,
  input wire logic [2:0] split_queue_strap_i,
  input wire logic [5:0] member_strap_i,
  // Ingress classification query
  input wire logic [1:0] cls_port_i,
  input wire logic cls_dot1p_hit_i,
  input wire logic cls_dot1p_high_i,
  input wire logic cls_dscp_hit_i,
  input wire logic cls_dscp_high_i,
  input wire logic [2:0] cls_user_prio_i,
  input wire logic [2:0] cls_default_prio_i,
  output logic cls_high_prio_o,
  output logic [2:0] cls_user_prio_o,
  // Egress tag query
  input wire logic [1:0] eg_port_i,
  input wire logic eg_rx_tagged_i,
  output logic eg_add_tag_o,
  output logic eg_strip_tag_o,
  // Per-port steering levels, index 0 is port 1
  output logic [2:0] storm_protect_o,
  output logic [2:0] split_queue_o,
  output logic [2:0] sniffer_port_o,
  output logic [2:0] rx_sniff_o,
  output logic [2:0] tx_sniff_o,
  output logic [2:0] double_tag_o,
  output logic [8:0] member_mask_o
);

  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic strap_load_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_q <= spqv_pkg::SYNC_ZERO;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // Straps are caught by the clock after release, never inside the reset
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      strap_load_q <= 1'b1;
    else
      strap_load_q <= 1'b0;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [1:0] port_of(input logic [7:0] a);
    // Port index from high nibble 1..3, 2'h3 marks no port
    begin
      unique case (a[7:4])
        4'h1: port_of = 2'h0;
        4'h2: port_of = 2'h1;
        4'h3: port_of = 2'h2;
        default: port_of = 2'h3;
      endcase
    end
  endfunction : port_of

  function automatic logic [2:0] member_reset(input logic [1:0] p, input logic [5:0] s);
    // Own port always a member; other two bits from straps
    begin
      unique case (p)
        2'h0: member_reset = {s[1], s[0], 1'b1};
        2'h1: member_reset = {s[3], 1'b1, s[2]};
        default: member_reset = {1'b1, s[5], s[4]};
      endcase
    end
  endfunction : member_reset

  // ==========================================================================
  // Register storage
  logic [7:0] ctl0_q [spqv_pkg::NUM_PORTS];
  logic [7:0] ctl1_q [spqv_pkg::NUM_PORTS];
  logic [1:0] wr_port;

  assign wr_port = port_of(addr_i);

  // Decode by nibbles; 0x10/0x11, 0x20/0x21, 0x30/0x31 only
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int p = 0; p < spqv_pkg::NUM_PORTS; p++)
      begin
        ctl0_q[p] <= spqv_pkg::BYTE_ZERO;
        ctl1_q[p] <= spqv_pkg::BYTE_ZERO;
      end
    end
    else if (strap_load_q)
    begin
      for (int p = 0; p < spqv_pkg::NUM_PORTS; p++)
      begin
        ctl0_q[p] <= spqv_pkg::BYTE_ZERO;
        ctl0_q[p][spqv_pkg::C0_DOT1P] <= dot1p_strap_i[p];
        ctl0_q[p][spqv_pkg::C0_PORT_PRIO] <= port_prio_strap_i[p];
        ctl0_q[p][spqv_pkg::C0_TAG_ADD] <= tag_add_strap_i[p];
        ctl0_q[p][spqv_pkg::C0_TAG_STRIP] <= tag_strip_strap_i[p];
        ctl0_q[p][spqv_pkg::C0_SPLIT_Q] <= split_queue_strap_i[p];
        ctl1_q[p] <= {5'h00, member_reset(2'(p), member_strap_i)};
      end
    end
    else if (wr_i && wr_port != 2'h3)
    begin
      if (addr_i[3:0] == spqv_pkg::ADDR_CTL0_LO)
        ctl0_q[wr_port] <= wdata_i;
      else if (addr_i[3:0] == spqv_pkg::ADDR_CTL1_LO)
        ctl1_q[wr_port] <= wdata_i; // Spare bit kept as written
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= spqv_pkg::BYTE_ZERO;
    else if (rd_i && wr_port != 2'h3 && addr_i[3:0] == spqv_pkg::ADDR_CTL0_LO)
      rdata_o <= ctl0_q[wr_port];
    else if (rd_i && wr_port != 2'h3 && addr_i[3:0] == spqv_pkg::ADDR_CTL1_LO)
      rdata_o <= ctl1_q[wr_port];
    else
      rdata_o <= spqv_pkg::BYTE_ZERO;
  end

  // ==========================================================================
  // Steering levels to the datapath
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      storm_protect_o <= spqv_pkg::MASK_ZERO;
      split_queue_o <= spqv_pkg::MASK_ZERO;
      sniffer_port_o <= spqv_pkg::MASK_ZERO;
      rx_sniff_o <= spqv_pkg::MASK_ZERO;
      tx_sniff_o <= spqv_pkg::MASK_ZERO;
      double_tag_o <= spqv_pkg::MASK_ZERO;
      member_mask_o <= 9'h000;
    end
    else
    begin
      for (int p = 0; p < spqv_pkg::NUM_PORTS; p++)
      begin
        storm_protect_o[p] <= ctl0_q[p][spqv_pkg::C0_STORM];
        split_queue_o[p] <= ctl0_q[p][spqv_pkg::C0_SPLIT_Q];
        sniffer_port_o[p] <= ctl1_q[p][spqv_pkg::C1_SNIFFER];
        rx_sniff_o[p] <= ctl1_q[p][spqv_pkg::C1_RX_SNIFF];
        tx_sniff_o[p] <= ctl1_q[p][spqv_pkg::C1_TX_SNIFF];
        double_tag_o[p] <= ctl1_q[p][spqv_pkg::C1_DOUBLE_TAG];
        member_mask_o[p*3 +: 3] <= ctl1_q[p][spqv_pkg::C1_MEMBER_HI:0];
      end
    end
  end

  // ==========================================================================
  // Ingress classification, one cycle behind the query
  logic [7:0] cls_c0;
  logic dscp_ok;
  logic dot1p_ok;

  assign cls_c0 = (cls_port_i == 2'h3) ? spqv_pkg::BYTE_ZERO : ctl0_q[cls_port_i];
  assign dscp_ok = cls_c0[spqv_pkg::C0_DIFFSERV] && cls_dscp_hit_i;
  assign dot1p_ok = cls_c0[spqv_pkg::C0_DOT1P] && cls_dot1p_hit_i;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cls_high_prio_o <= 1'b0;
      cls_user_prio_o <= spqv_pkg::PRIO_ZERO;
    end
    else
    begin
      // Enabled classifiers OR together and override port priority
      if (dscp_ok || dot1p_ok)
        cls_high_prio_o <= (dscp_ok && cls_dscp_high_i) || (dot1p_ok && cls_dot1p_high_i);
      else
        cls_high_prio_o <= cls_c0[spqv_pkg::C0_PORT_PRIO];
      if (cls_c0[spqv_pkg::C0_PRIO_CEIL] && cls_user_prio_i > cls_default_prio_i)
        cls_user_prio_o <= cls_default_prio_i;
      else
        cls_user_prio_o <= cls_user_prio_i;
    end
  end

  // ==========================================================================
  // Egress tag decision, one cycle behind the query
  logic [7:0] eg_c0;

  assign eg_c0 = (eg_port_i == 2'h3) ? spqv_pkg::BYTE_ZERO : ctl0_q[eg_port_i];

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eg_add_tag_o <= 1'b0;
      eg_strip_tag_o <= 1'b0;
    end
    else
    begin
      eg_add_tag_o <= eg_c0[spqv_pkg::C0_TAG_ADD] && !eg_rx_tagged_i;
      eg_strip_tag_o <= eg_c0[spqv_pkg::C0_TAG_STRIP] && eg_rx_tagged_i;
    end
  end

endmodule : spqv_port_ctrl

// ==== design/spqv_pkg.sv ====
/*
 * Package for the per-port priority, tagging and mirroring control bank.
 * Assumes a byte-wide register port and three switch ports.
 */
package spqv_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned NUM_PORTS = 3;
  localparam logic [7:0] ADDR_P1_PRIO_TAG = 8'h10;
  localparam logic [7:0] ADDR_P1_MIRROR_VLAN = 8'h11;
  localparam logic [7:0] ADDR_P2_PRIO_TAG = 8'h20;
  localparam logic [7:0] ADDR_P2_MIRROR_VLAN = 8'h21;
  localparam logic [7:0] ADDR_P3_PRIO_TAG = 8'h30;
  localparam logic [7:0] ADDR_P3_MIRROR_VLAN = 8'h31;
  localparam logic [3:0] ADDR_PORT_STEP_HI = 4'h1;
  localparam logic [3:0] ADDR_CTL0_LO = 4'h0;
  localparam logic [3:0] ADDR_CTL1_LO = 4'h1;

  // ==========================================================================
  // Control 0 fields
  localparam int unsigned C0_STORM = 7;
  localparam int unsigned C0_DIFFSERV = 6;
  localparam int unsigned C0_DOT1P = 5;
  localparam int unsigned C0_PORT_PRIO = 4;
  localparam int unsigned C0_PRIO_CEIL = 3;
  localparam int unsigned C0_TAG_ADD = 2;
  localparam int unsigned C0_TAG_STRIP = 1;
  localparam int unsigned C0_SPLIT_Q = 0;

  // ==========================================================================
  // Control 1 fields
  localparam int unsigned C1_SNIFFER = 7;
  localparam int unsigned C1_RX_SNIFF = 6;
  localparam int unsigned C1_TX_SNIFF = 5;
  localparam int unsigned C1_DOUBLE_TAG = 4;
  localparam int unsigned C1_SPARE = 3;
  localparam int unsigned C1_MEMBER_HI = 2;

  // ==========================================================================
  // Reset and misc values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] PRIO_ZERO = 3'h0;
  localparam logic [2:0] MASK_ZERO = 3'h0;
  localparam logic [1:0] SYNC_ZERO = 2'h0;
  localparam logic [1:0] SYNC_ONE = 2'h1;

endpackage : spqv_pkg

// ==== verification/spqv_port_ctrl_asserts.sv ====
/*
 * Port-level checker for the per-port control bank.
 * Assumes binding to spqv_port_ctrl; outputs lag a write by two edges.
 */
module spqv_port_ctrl_asserts
(
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Queries
  input wire logic [1:0] cls_port_i,
  input wire logic [2:0] cls_user_prio_i,
  input wire logic [2:0] cls_default_prio_i,
  input wire logic cls_high_prio_o,
  input wire logic [2:0] cls_user_prio_o,
  input wire logic [1:0] eg_port_i,
  input wire logic eg_add_tag_o,
  input wire logic eg_strip_tag_o,
  // Steering
  input wire logic [2:0] storm_protect_o,
  input wire logic [2:0] split_queue_o,
  input wire logic [2:0] sniffer_port_o,
  input wire logic [2:0] rx_sniff_o,
  input wire logic [2:0] double_tag_o,
  input wire logic [8:0] member_mask_o
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_storm_follows: assert property (wr_i && addr_i == 8'h10 |=> ##1 storm_protect_o[0] == $past(wdata_i[7], 2))
    else $error("storm enable mismatch");
  a_split_follows: assert property (wr_i && addr_i == 8'h20 |=> ##1 split_queue_o[1] == $past(wdata_i[0], 2))
    else $error("split queue mismatch");
  a_sniffer_follows: assert property (wr_i && addr_i == 8'h31 |=> ##1 sniffer_port_o[2] == $past(wdata_i[7], 2))
    else $error("sniffer mismatch");
  a_rx_sniff: assert property (wr_i && addr_i == 8'h21 |=> ##1 rx_sniff_o[1] == $past(wdata_i[6], 2))
    else $error("receive sniff mismatch");
  a_double_tag: assert property (wr_i && addr_i == 8'h11 |=> ##1 double_tag_o[0] == $past(wdata_i[4], 2))
    else $error("double tag mismatch");
  a_member_mask: assert property (wr_i && addr_i == 8'h11 |=> ##1 member_mask_o[2:0] == $past(wdata_i[2:0], 2))
    else $error("membership mismatch");
  a_unmapped_read: assert property (rd_i && addr_i[3:1] != 3'h0 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_no_port_idle: assert property (cls_port_i == 2'h3 && eg_port_i == 2'h3 |=> !cls_high_prio_o && !eg_add_tag_o && !eg_strip_tag_o)
    else $error("query without port not idle");
  a_ceiling_keep: assert property (cls_user_prio_i <= cls_default_prio_i |=> cls_user_prio_o == $past(cls_user_prio_i))
    else $error("priority changed below ceiling");
endmodule : spqv_port_ctrl_asserts

bind spqv_port_ctrl spqv_port_ctrl_asserts u_spqv_port_ctrl_asserts (.*);

// ==== verification/test_spqv_port_ctrl.sv ====
/*
 * Self-checking bench for the per-port control bank.
 * Assumes straps stable from time zero and one-cycle query latency.
 */
module test_spqv_port_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, wr_i, rd_i, cls_dot1p_hit_i, cls_dot1p_high_i, cls_dscp_hit_i, cls_dscp_high_i;
  logic eg_rx_tagged_i, cls_high_prio_o, eg_add_tag_o, eg_strip_tag_o;
  logic [7:0] addr_i, wdata_i, rdata_o, v0, v1;
  logic [1:0] cls_port_i, eg_port_i;
  logic [2:0] cls_user_prio_i, cls_default_prio_i, cls_user_prio_o, storm_protect_o, split_queue_o;
  logic [2:0] sniffer_port_o, rx_sniff_o, tx_sniff_o, double_tag_o;
  logic [2:0] dot1p_strap_i = 3'h5, port_prio_strap_i = 3'h2, tag_add_strap_i = 3'h1;
  logic [2:0] tag_strip_strap_i = 3'h4, split_queue_strap_i = 3'h3;
  logic [5:0] member_strap_i = 6'h27;
  logic [8:0] member_mask_o;
  int err_total, checks_done;

  spqv_port_ctrl u_spqv_port_ctrl (.*);

  initial
  begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
      $display("ERROR at %0t: got %h expected %h (%0d)", $time, got, exp, ++err_total);
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd
  task automatic cls(input logic [3:0] h, input logic [2:0] up, dp, input logic eh, input logic [2:0] eu);
    @(posedge clk_i);
    {cls_dot1p_hit_i, cls_dot1p_high_i, cls_dscp_hit_i, cls_dscp_high_i} <= h;
    {cls_user_prio_i, cls_default_prio_i} <= {up, dp};
    @(posedge clk_i);
    #1 chk({cls_high_prio_o, cls_user_prio_o}, {eh, eu});
  endtask : cls
  task automatic eg(input logic t, input logic [1:0] exp);
    @(posedge clk_i);
    eg_rx_tagged_i <= t;
    @(posedge clk_i);
    #1 chk({eg_add_tag_o, eg_strip_tag_o}, exp);
  endtask : eg
  task automatic stop_test;
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Sequence
  initial
  begin
    {rst_n_i, wr_i, rd_i, addr_i, wdata_i, eg_rx_tagged_i} = 0;
    {cls_dot1p_hit_i, cls_dot1p_high_i, cls_dscp_hit_i, cls_dscp_high_i} = 0;
    {cls_user_prio_i, cls_default_prio_i, cls_port_i, eg_port_i} = 10'h00F;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 chk(member_mask_o, 9'h19F);
    chk(split_queue_o, 3'h3);
    rd(8'h10, 8'h25);
    rd(8'h20, 8'h11);
    rd(8'h30, 8'h22);
    rd(8'h21, 8'h03);
    for (int p = 0; p < 3; p++)
    begin
      v0 = 8'hC9 ^ 8'(p * 8'h36);
      v1 = 8'hF8 ^ 8'(p * 8'h5B);
      wr(8'(p * 16 + 16), v0);
      wr(8'(p * 16 + 17), v1);
      rd(8'(p * 16 + 16), v0);
      rd(8'(p * 16 + 17), v1);
      chk({storm_protect_o[p], split_queue_o[p], sniffer_port_o[p], rx_sniff_o[p], tx_sniff_o[p], double_tag_o[p]},
        {v0[7], v0[0], v1[7:4]});
      chk(member_mask_o[3*p +: 3], v1[2:0]);
    end
    wr(8'h12, 8'hFF);
    wr(8'h40, 8'hFF);
    rd(8'h12, 8'h00);
    rd(8'h10, 8'hC9);
    wr(8'h10, 8'h78);
    {cls_port_i, eg_port_i} <= 4'h0;
    cls(4'h0, 3'h5, 3'h3, 1'b1, 3'h3);
    cls(4'h8, 3'h3, 3'h3, 1'b0, 3'h3);
    cls(4'hB, 3'h2, 3'h3, 1'b1, 3'h2);
    wr(8'h10, 8'h00);
    cls(4'h0, 3'h7, 3'h1, 1'b0, 3'h7);
    cls(4'hF, 3'h0, 3'h0, 1'b0, 3'h0);
    wr(8'h10, 8'h20);
    cls(4'hC, 3'h0, 3'h0, 1'b1, 3'h0);
    wr(8'h10, 8'h40);
    cls(4'h3, 3'h0, 3'h0, 1'b1, 3'h0);
    wr(8'h10, 8'h04);
    eg(1'b0, 2'h2);
    eg(1'b1, 2'h0);
    wr(8'h10, 8'h02);
    eg(1'b1, 2'h1);
    eg(1'b0, 2'h0);
    stop_test();
  end

  // Guards against a stalled sequence
  initial
  begin
    #100us;
    err_total++;
    stop_test();
  end
endmodule : test_spqv_port_ctrl
